// ### rtl/ext_mem_rd_defs.vh
// constants for the external memory read strobe block
// Notes on behaviour
// - read strobe is low for every external read cycle, high otherwise.
// - while read strobe is low all sixteen data pins are inputs.
// - data bus is captured into the read register as the strobe rises.
// - space selects are qualified by the asserted read strobe; address pins hold the last read address.
// - idle bus: read strobe floats or stays driven per the drive-keep bit.
// - control pull-up disable bit set turns off the read strobe pull-up.
// - clearing a port F pull-up enable bit disables that data pin pull-up.
// - after reset the upper data pins take the data bus role, not GPIO.
`ifndef EXT_MEM_RD_DEFS_VH
`define EXT_MEM_RD_DEFS_VH
`define OFF_BUS_CONTROL 4'h0
`define OFF_PULLUP_DISABLE 4'h4
`define OFF_PORTF_PULLUP 4'h8
`define OFF_STATUS 4'hC
`define BIT_DRIVE_KEEP 0
`define BIT_CTRL_PUD 0
`define BIT_PORTF_SEL 1
`define RST_BUS_CONTROL 32'h00000000
`define RST_PULLUP_DISABLE 32'h00000000
`define RST_PORTF_PULLUP 32'h0000FFFF
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10
`define ST_IDLE 2'h0
`define ST_STROBE 2'h1
`define ST_DONE 2'h2
`define DEFAULT_STROBE_CYCLES 4
`endif

// ### rtl/rd_strobe_seq.v
// read strobe sequencer: strobe low for a set number of cycles, capture on rise
`default_nettype none
`include "ext_mem_rd_defs.vh"
module rd_strobe_seq #(
  parameter DW = 16,
  parameter AW = 17,
  parameter STROBE_CYCLES = `DEFAULT_STROBE_CYCLES
) (
  input wire mclk_in,
  input wire resetn_in,
  input wire start_in,
  input wire [AW-1:0] addr_in,
  input wire prog_space_in,
  input wire wr_busy_in,
  input wire [DW-1:0] data_pins_in,
  output reg busy_out,
  output reg done_out,
  output reg rd_n_out,
  output reg [AW-1:0] addr_out,
  output reg ps_n_out,
  output reg ds_n_out,
  output reg [DW-1:0] rdata_out
);
  reg [1:0] st_q;
  reg [7:0] cnt_q;
  always @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      st_q <= `ST_IDLE;
      cnt_q <= 8'h00;
      busy_out <= 1'b0;
      done_out <= 1'b0;
      rd_n_out <= 1'b1;
      addr_out <= {AW{1'b0}};
      ps_n_out <= 1'b1;
      ds_n_out <= 1'b1;
      rdata_out <= {DW{1'b0}};
    end else begin
      done_out <= 1'b0;
      case (st_q)
        `ST_IDLE: begin
          // wait for the write side to be quiet so both strobes never overlap
          if (start_in && !wr_busy_in) begin
            st_q <= `ST_STROBE;
            busy_out <= 1'b1;
            cnt_q <= STROBE_CYCLES[7:0] - 8'h01;
            rd_n_out <= 1'b0;
            addr_out <= addr_in;
            ps_n_out <= ~prog_space_in;
            ds_n_out <= prog_space_in;
          end
        end
        `ST_STROBE: begin
          if (cnt_q == 8'h00) begin
            // internal strobe rises here; the registered pin copy rises one edge later
            rd_n_out <= 1'b1;
            ps_n_out <= 1'b1;
            ds_n_out <= 1'b1;
            st_q <= `ST_DONE;
          end else begin
            cnt_q <= cnt_q - 8'h01;
          end
        end
        `ST_DONE: begin
          // sampled at the edge where the strobe pin rises, while the memory still drives the bus
          rdata_out <= data_pins_in;
          done_out <= 1'b1;
          busy_out <= 1'b0;
          st_q <= `ST_IDLE;
        end
        default: begin
          st_q <= `ST_IDLE;
          rd_n_out <= 1'b1;
          busy_out <= 1'b0;
        end
      endcase
    end
  end
endmodule // rd_strobe_seq
`default_nettype wire

// ### rtl/ext_mem_read_strobe_pins.v
// external memory read strobe pins with AXI4-Lite control registers
`default_nettype none
`include "ext_mem_rd_defs.vh"
module ext_mem_read_strobe_pins #(
  parameter DW = 16,
  parameter AW = 17,
  parameter STROBE_CYCLES = `DEFAULT_STROBE_CYCLES
) (
  input wire mclk_in,
  input wire resetn_in,
  input wire [3:0] s_axi_awaddr_in,
  input wire s_axi_awvalid_in,
  output reg s_axi_awready_out,
  input wire [31:0] s_axi_wdata_in,
  input wire [3:0] s_axi_wstrb_in,
  input wire s_axi_wvalid_in,
  output reg s_axi_wready_out,
  output reg [1:0] s_axi_bresp_out,
  output reg s_axi_bvalid_out,
  input wire s_axi_bready_in,
  input wire [3:0] s_axi_araddr_in,
  input wire s_axi_arvalid_in,
  output reg s_axi_arready_out,
  output reg [31:0] s_axi_rdata_out,
  output reg [1:0] s_axi_rresp_out,
  output reg s_axi_rvalid_out,
  input wire s_axi_rready_in,
  input wire rd_req_in,
  input wire [AW-1:0] rd_addr_in,
  input wire rd_prog_space_in,
  input wire wr_busy_in,
  output reg rd_busy_out,
  output reg rd_done_out,
  output reg [DW-1:0] rd_data_out,
  input wire [DW-1:0] ext_data_pins_in,
  output reg ext_data_pins_oe_out,
  output reg [AW-1:0] ext_address_pins_out,
  output reg program_space_select_n_out,
  output reg data_space_select_n_out,
  output reg rd_n_out,
  output reg rd_n_oe_out,
  output reg rd_pullup_en_out,
  output reg [DW-1:0] data_pullup_en_out,
  output reg port_f_gpio_sel_out
);
  reg [31:0] bus_control_reg_q;
  reg [31:0] system_pullup_disable_reg_q;
  reg [31:0] port_f_pullup_enable_q;
  reg [3:0] awaddr_q;
  reg [31:0] wdata_q;
  reg [3:0] wstrb_q;
  reg aw_have_q;
  reg w_have_q;
  reg [15:0] rd_count_q;
  wire seq_busy;
  wire seq_done;
  wire seq_rd_n;
  wire [AW-1:0] seq_addr;
  wire seq_ps_n;
  wire seq_ds_n;
  wire [DW-1:0] seq_rdata;
  wire seq_start;
  wire drive_keep;
  wire gpio_mode;

  assign drive_keep = bus_control_reg_q[`BIT_DRIVE_KEEP];
  assign gpio_mode = bus_control_reg_q[`BIT_PORTF_SEL];
  // in gpio mode the shared pins are not bus pins, so no read is started
  // a refused start must not show as busy, so the write side gates it here too
  assign seq_start = rd_req_in && !rd_busy_out && !gpio_mode && !wr_busy_in;

  rd_strobe_seq #(
    .DW(DW),
    .AW(AW),
    .STROBE_CYCLES(STROBE_CYCLES)
  ) u_seq (
    .mclk_in(mclk_in),
    .resetn_in(resetn_in),
    .start_in(seq_start),
    .addr_in(rd_addr_in),
    .prog_space_in(rd_prog_space_in),
    .wr_busy_in(wr_busy_in),
    .data_pins_in(ext_data_pins_in),
    .busy_out(seq_busy),
    .done_out(seq_done),
    .rd_n_out(seq_rd_n),
    .addr_out(seq_addr),
    .ps_n_out(seq_ps_n),
    .ds_n_out(seq_ds_n),
    .rdata_out(seq_rdata)
  );

  // pin stage: one register stage keeps every output flop-driven
  always @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rd_n_out <= 1'b1;
      rd_n_oe_out <= 1'b0;
      ext_data_pins_oe_out <= 1'b0;
      ext_address_pins_out <= {AW{1'b0}};
      program_space_select_n_out <= 1'b1;
      data_space_select_n_out <= 1'b1;
      rd_busy_out <= 1'b0;
      rd_done_out <= 1'b0;
      rd_data_out <= {DW{1'b0}};
      rd_pullup_en_out <= 1'b1;
      data_pullup_en_out <= {DW{1'b1}};
      port_f_gpio_sel_out <= 1'b0;
      rd_count_q <= 16'h0000;
    end else begin
      rd_n_out <= seq_rd_n;
      // active strobe always driven; idle strobe floats unless drive-keep
      rd_n_oe_out <= !seq_rd_n || drive_keep;
      ext_data_pins_oe_out <= 1'b0;
      ext_address_pins_out <= seq_addr;
      program_space_select_n_out <= seq_ps_n;
      data_space_select_n_out <= seq_ds_n;
      rd_busy_out <= seq_busy || seq_start;
      rd_done_out <= seq_done;
      rd_data_out <= seq_rdata;
      rd_pullup_en_out <= !system_pullup_disable_reg_q[`BIT_CTRL_PUD];
      data_pullup_en_out <= port_f_pullup_enable_q[DW-1:0];
      port_f_gpio_sel_out <= gpio_mode;
      if (seq_done) begin
        rd_count_q <= rd_count_q + 16'h0001;
      end
    end
  end

  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0] be;
    integer i;
    begin
      merge = old;
      for (i = 0; i < 4; i = i + 1) begin
        if (be[i]) begin
          merge[i*8 +: 8] = nw[i*8 +: 8];
        end
      end
    end
  endfunction

  // write channel: address and data taken in either order, response after both
  always @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      s_axi_awready_out <= 1'b0;
      s_axi_wready_out <= 1'b0;
      s_axi_bvalid_out <= 1'b0;
      s_axi_bresp_out <= `RESP_OKAY;
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awaddr_q <= 4'h0;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
      bus_control_reg_q <= `RST_BUS_CONTROL;
      system_pullup_disable_reg_q <= `RST_PULLUP_DISABLE;
      port_f_pullup_enable_q <= `RST_PORTF_PULLUP;
    end else begin
      s_axi_awready_out <= !aw_have_q && !s_axi_awready_out && s_axi_awvalid_in && !s_axi_bvalid_out;
      s_axi_wready_out <= !w_have_q && !s_axi_wready_out && s_axi_wvalid_in && !s_axi_bvalid_out;
      if (s_axi_awvalid_in && s_axi_awready_out) begin
        aw_have_q <= 1'b1;
        awaddr_q <= s_axi_awaddr_in;
      end
      if (s_axi_wvalid_in && s_axi_wready_out) begin
        w_have_q <= 1'b1;
        wdata_q <= s_axi_wdata_in;
        wstrb_q <= s_axi_wstrb_in;
      end
      if (aw_have_q && w_have_q && !s_axi_bvalid_out) begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        s_axi_bvalid_out <= 1'b1;
        s_axi_bresp_out <= `RESP_OKAY;
        case (awaddr_q)
          `OFF_BUS_CONTROL: begin
            bus_control_reg_q <= merge(bus_control_reg_q, wdata_q, wstrb_q) & 32'h00000003;
          end
          `OFF_PULLUP_DISABLE: begin
            system_pullup_disable_reg_q <= merge(system_pullup_disable_reg_q, wdata_q, wstrb_q) & 32'h00000001;
          end
          `OFF_PORTF_PULLUP: begin
            port_f_pullup_enable_q <= merge(port_f_pullup_enable_q, wdata_q, wstrb_q) & 32'h0000FFFF;
          end
          `OFF_STATUS: begin
            s_axi_bresp_out <= `RESP_OKAY;
          end
          default: begin
            s_axi_bresp_out <= `RESP_SLVERR;
          end
        endcase
      end else if (s_axi_bvalid_out && s_axi_bready_in) begin
        s_axi_bvalid_out <= 1'b0;
      end
    end
  end

  // read channel: one cycle to accept, data one cycle later
  always @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      s_axi_arready_out <= 1'b0;
      s_axi_rvalid_out <= 1'b0;
      s_axi_rdata_out <= 32'h00000000;
      s_axi_rresp_out <= `RESP_OKAY;
    end else begin
      s_axi_arready_out <= !s_axi_arready_out && s_axi_arvalid_in && !s_axi_rvalid_out;
      if (s_axi_arvalid_in && s_axi_arready_out) begin
        s_axi_rvalid_out <= 1'b1;
        s_axi_rresp_out <= `RESP_OKAY;
        case (s_axi_araddr_in)
          `OFF_BUS_CONTROL: s_axi_rdata_out <= bus_control_reg_q;
          `OFF_PULLUP_DISABLE: s_axi_rdata_out <= system_pullup_disable_reg_q;
          `OFF_PORTF_PULLUP: s_axi_rdata_out <= port_f_pullup_enable_q;
          `OFF_STATUS: s_axi_rdata_out <= {rd_count_q, 14'h0000, !rd_n_out, rd_busy_out};
          default: begin
            s_axi_rdata_out <= 32'h00000000;
            s_axi_rresp_out <= `RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid_out && s_axi_rready_in) begin
        s_axi_rvalid_out <= 1'b0;
      end
    end
  end
endmodule // ext_mem_read_strobe_pins
`default_nettype wire

// ### verification/ext_mem_rd_monitor.sv
// concurrent checks on the read strobe pins
`default_nettype none
module ext_mem_rd_monitor (
  input wire logic mclk_in,
  input wire logic resetn_in,
  input wire logic wr_busy_in,
  input wire logic rd_busy_out,
  input wire logic rd_done_out,
  input wire logic [15:0] rd_data_out,
  input wire logic [15:0] ext_data_pins_in,
  input wire logic ext_data_pins_oe_out,
  input wire logic program_space_select_n_out,
  input wire logic data_space_select_n_out,
  input wire logic rd_n_out,
  input wire logic rd_n_oe_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge mclk_in);
  endclocking
  default disable iff (!resetn_in);
  // the fixed 4 assumes the default strobe width
  sequence strobe_s;
    (!rd_n_out) [*4] ##1 rd_n_out;
  endsequence
  sequence read_s;
    $fell(rd_n_out) ##4 rd_n_out ##1 rd_done_out;
  endsequence
  strobe_len_a: assert property ($fell(rd_n_out) |-> strobe_s) else $error("strobe width wrong");
  read_walk_a: assert property ($rose(rd_busy_out) |-> ##1 read_s) else $error("read walk wrong");
  data_in_a: assert property (!rd_n_out |-> !ext_data_pins_oe_out) else $error("data driven in read");
  capture_a: assert property (rd_done_out |-> rd_data_out == $past(ext_data_pins_in, 2))
    else $error("capture wrong");
  select_qual_a: assert property ((!program_space_select_n_out || !data_space_select_n_out) |->
    !rd_n_out && (program_space_select_n_out ^ data_space_select_n_out)) else $error("select outside strobe");
  strobe_drive_a: assert property (!rd_n_out |-> rd_n_oe_out) else $error("strobe floats");
  no_clash_a: assert property ($rose(rd_busy_out) |-> !$past(wr_busy_in)) else $error("read during write");
  done_pulse_a: assert property (rd_done_out |-> !rd_busy_out ##1 !rd_done_out) else $error("done not a pulse");
endmodule // ext_mem_rd_monitor
bind ext_mem_read_strobe_pins ext_mem_rd_monitor mon (.mclk_in(mclk_in), .resetn_in(resetn_in),
  .wr_busy_in(wr_busy_in), .rd_busy_out(rd_busy_out), .rd_done_out(rd_done_out), .rd_data_out(rd_data_out),
  .ext_data_pins_in(ext_data_pins_in), .ext_data_pins_oe_out(ext_data_pins_oe_out),
  .program_space_select_n_out(program_space_select_n_out), .data_space_select_n_out(data_space_select_n_out),
  .rd_n_out(rd_n_out), .rd_n_oe_out(rd_n_oe_out));
`default_nettype wire

// ### verification/sram_model.sv
// behavioural external static memory answering read strobes
`default_nettype none
module sram_model (
  input wire logic mclk_in,
  input wire logic rd_n_in,
  input wire logic ps_n_in,
  input wire logic ds_n_in,
  input wire logic [16:0] addr_in,
  input wire logic [15:0] pullup_en_in,
  output var logic [15:0] dq_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial dq_out = 16'hA5A5;
  // released bus: pulled-up pins float high, the rest toggle so a stale capture cannot pass
  always @(posedge mclk_in) begin
    if (!rd_n_in && (ps_n_in ^ ds_n_in)) dq_out <= addr_in[15:0] ^ (ps_n_in ? 16'h5A3C : 16'h0F0F);
    else dq_out <= ~dq_out | pullup_en_in;
  end
endmodule // sram_model
`default_nettype wire

// ### verification/testbench.sv
// self-checking bench for the read strobe pins
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk_in = 0, resetn_in = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic rd_req = 0, rd_ps = 0, wr_busy = 0;
  logic [3:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rv, d;
  logic [1:0] rr;
  logic [16:0] rd_addr = 0;
  logic [15:0] exp_q[$];
  wire logic awready, wready, bvalid, arready, rvalid, dq_oe, rd_busy, rd_done, ps_n, ds_n, rd_n, rd_n_oe, rd_pu, gsel;
  wire logic [1:0] bresp, rresp;
  wire logic [31:0] rdata;
  wire logic [15:0] rd_data, dq, dpu;
  wire logic [16:0] addr;
  int mismatches = 0, n_compared = 0, cyc = 0, seed = 25885, nrd = 0;
  always #5 mclk_in = ~mclk_in;
  ext_mem_read_strobe_pins dut (.mclk_in(mclk_in), .resetn_in(resetn_in), .s_axi_awaddr_in(awaddr),
    .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready), .s_axi_wdata_in(wdata), .s_axi_wstrb_in(4'hF),
    .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid),
    .s_axi_bready_in(bready), .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready),
    .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready),
    .rd_req_in(rd_req), .rd_addr_in(rd_addr), .rd_prog_space_in(rd_ps), .wr_busy_in(wr_busy),
    .rd_busy_out(rd_busy), .rd_done_out(rd_done), .rd_data_out(rd_data), .ext_data_pins_in(dq),
    .ext_data_pins_oe_out(dq_oe), .ext_address_pins_out(addr), .program_space_select_n_out(ps_n),
    .data_space_select_n_out(ds_n), .rd_n_out(rd_n), .rd_n_oe_out(rd_n_oe), .rd_pullup_en_out(rd_pu),
    .data_pullup_en_out(dpu), .port_f_gpio_sel_out(gsel));
  sram_model mem (.mclk_in(mclk_in), .rd_n_in(rd_n), .ps_n_in(ps_n), .ds_n_in(ds_n), .addr_in(addr),
    .pullup_en_in(dpu), .dq_out(dq));
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic close_out;
    if (mismatches == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  always @(posedge mclk_in) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      close_out();
    end
  end
  task automatic axw(input logic [3:0] a, input logic [31:0] v);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    do begin
      @(posedge mclk_in);
      if (awready) awvalid <= 0;
      if (wready) wvalid <= 0;
    end while (bvalid !== 1'b1);
    rr = bresp;
    bready <= 0;
    @(posedge mclk_in);
  endtask
  task automatic axr(input logic [3:0] a);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    do begin
      @(posedge mclk_in);
      if (arready) arvalid <= 0;
    end while (rvalid !== 1'b1);
    rv = rdata;
    rr = rresp;
    rready <= 0;
    @(posedge mclk_in);
  endtask
  task automatic wr_chk(input logic [3:0] a, input logic [31:0] v, input logic [31:0] msk);
    axw(a, v);
    chk(rr, 2'b00);
    axr(a);
    chk(rv, v & msk);
    repeat (2) @(posedge mclk_in);
  endtask
  task automatic rd(input bit blk);
    logic [16:0] a;
    logic p;
    int k;
    a = $random(seed);
    p = $random(seed);
    k = 0;
    exp_q.push_back(a[15:0] ^ (p ? 16'h0F0F : 16'h5A3C));
    rd_addr <= a;
    rd_ps <= p;
    rd_req <= 1;
    wr_busy <= blk;
    if (blk) begin
      repeat (5) @(posedge mclk_in);
      chk(rd_busy, 0);
      wr_busy <= 0;
    end
    do begin
      @(posedge mclk_in);
      k++;
    end while (rd_busy !== 1'b1 && k < 20);
    rd_req <= 0;
    do begin
      @(posedge mclk_in);
      k++;
    end while (rd_done !== 1'b1 && k < 40);
    chk(rd_data, exp_q.pop_front());
    nrd++;
  endtask
  initial begin
    repeat (2) @(posedge mclk_in);
    resetn_in <= 1;
    @(posedge mclk_in);
    chk({rd_n, rd_n_oe, rd_pu, gsel}, 4'hA);
    chk(dpu, 16'hFFFF);
    axr(4'h6);
    chk(rr, 2'b10);
    chk(rv, 32'h0);
    axw(4'hC, 32'hFFFFFFFF);
    chk(rr, 2'b00);
    axr(4'hC);
    chk(rv, 0);
    rd(0);
    wr_chk(4'h0, 32'h1, 32'h3);
    chk(rd_n_oe, 1);
    d = $random(seed);
    wr_chk(4'h4, d, 32'h1);
    chk(rd_pu, !d[0]);
    d = $random(seed);
    wr_chk(4'h8, d, 32'hFFFF);
    chk(dpu, d[15:0]);
    wr_chk(4'h0, 32'h3, 32'h3);
    chk(gsel, 1);
    rd_req <= 1;
    repeat (6) @(posedge mclk_in);
    chk(rd_busy, 0);
    rd_req <= 0;
    wr_chk(4'h0, 32'h1, 32'h3);
    for (int i = 0; i < 20; i++) rd(i % 4 == 0);
    axr(4'hC);
    chk(rv, nrd << 16);
    close_out();
  end
endmodule // testbench
`default_nettype wire
